// [mhed_pkg.sv]
package mhed_pkg;
	// consecutive agreeing samples needed for a hookswitch decision
	localparam int unsigned HOOK_SAMPLES = 10;
	localparam logic [3:0] HOOK_CNT_MAX = 4'hA;
	// mic presence qualification: samples needed when debounce is on
	localparam logic [3:0] MIC_DB_CNT_MAX = 4'h4;
	// samples the hookswitch pre-filter needs when its debounce is on (one when off)
	localparam logic [3:0] HOOK_DB_CNT_MAX = 4'h4;
	localparam logic RST_FLAG = 1'b0;
	localparam logic [3:0] RST_CNT = 4'h0;
	// sample rate divider: one comparator sample every N clocks
	localparam int unsigned SAMPLE_PERIOD_NS = 1000;
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned SAMPLE_DIV = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [7:0] SAMPLE_DIV_MAX = 8'(SAMPLE_DIV - 1);

	typedef struct packed {
		logic mic_present_event_polarity;
		logic mic_present_debounce_enable;
		logic hookswitch_event_polarity;
		logic hookswitch_debounce_enable;
	} mhed_cfg_type;

	typedef struct packed {
		logic mic_present_flag_clear;
		logic hookswitch_flag_clear;
	} mhed_clr_type;
endpackage

// [mhed_qualifier.sv]
`timescale 1ns/100ps
// a level is accepted only after max_in consecutive agreeing samples
module mhed_qualifier
	import mhed_pkg::*;
(
	// clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// samples
	input wire logic sample_en_in,
	input wire logic level_in,
	input wire logic [3:0] max_in,
	// result
	output logic state_out
);
	logic [3:0] cnt_q, cnt_d;
	logic state_q, state_d;

	always_comb begin
		cnt_d = cnt_q;
		state_d = state_q;
		if (sample_en_in) begin
			if (level_in == state_q) begin
				cnt_d = RST_CNT;
			end else if (cnt_q + 4'h1 >= max_in) begin
				state_d = level_in;
				cnt_d = RST_CNT;
			end else begin
				cnt_d = cnt_q + 4'h1;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			cnt_q <= RST_CNT;
			state_q <= RST_FLAG;
		end else begin
			cnt_q <= cnt_d;
			state_q <= state_d;
		end
	end

	assign state_out = state_q;
endmodule

// [mhed_event_detect.sv]
`timescale 1ns/100ps
// Function
// - press flags after ten samples above threshold
// - release flags after ten samples below threshold
// - mic polarity 0 insertion, 1 removal
// - hook polarity 0 press, 1 release
// - mic debounce active only when enabled
// - hook debounce active only when enabled
// - detection states shown on status pin
// - pin changes carry same detect delays
module mhed_event_detect
	import mhed_pkg::*;
(
	// clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// comparator levels from the analogue front end (async)
	input wire logic mic_present_cmp_in,
	input wire logic hookswitch_cmp_in,
	// configuration and flag clears
	input wire mhed_cfg_type cfg_in,
	input wire mhed_clr_type clr_in,
	// flags and status pin
	output logic mic_present_event_flag_out,
	output logic hookswitch_event_flag_out,
	output logic mic_present_state_out,
	output logic hookswitch_state_out
);
	logic [2:0] mic_sync_q, mic_sync_d;
	logic [2:0] hook_sync_q, hook_sync_d;
	logic mic_lvl_q, mic_lvl_d;
	logic hook_lvl_q, hook_lvl_d;
	logic [7:0] div_q, div_d;
	logic sample_q, sample_d;
	logic mic_flag_q, mic_flag_d;
	logic hook_flag_q, hook_flag_d;
	logic mic_pin_q, mic_pin_d;
	logic hook_pin_q, hook_pin_d;
	logic mic_state, hook_raw, hook_state;
	logic [3:0] mic_max, hook_max;
	logic mic_hit, hook_hit;

	// input sync: accept a change once stages two and three agree
	always_comb begin
		mic_sync_d = {mic_sync_q[1:0], mic_present_cmp_in};
		hook_sync_d = {hook_sync_q[1:0], hookswitch_cmp_in};
		mic_lvl_d = mic_lvl_q;
		hook_lvl_d = hook_lvl_q;
		if (mic_sync_q[2] == mic_sync_q[1]) begin
			mic_lvl_d = mic_sync_q[2];
		end
		if (hook_sync_q[2] == hook_sync_q[1]) begin
			hook_lvl_d = hook_sync_q[2];
		end
		div_d = (div_q == SAMPLE_DIV_MAX) ? 8'h00 : div_q + 8'h01;
		sample_d = (div_q == SAMPLE_DIV_MAX);
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			mic_sync_q <= 3'h0;
			hook_sync_q <= 3'h0;
			mic_lvl_q <= 1'b0;
			hook_lvl_q <= 1'b0;
			div_q <= 8'h00;
			sample_q <= 1'b0;
		end else begin
			mic_sync_q <= mic_sync_d;
			hook_sync_q <= hook_sync_d;
			mic_lvl_q <= mic_lvl_d;
			hook_lvl_q <= hook_lvl_d;
			div_q <= div_d;
			sample_q <= sample_d;
		end
	end

	// debounce off means one sample suffices for mic
	assign mic_max = cfg_in.mic_present_debounce_enable ?
		MIC_DB_CNT_MAX : 4'h1;
	mhed_qualifier u_mic_q (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.sample_en_in(sample_q),
		.level_in(mic_lvl_q),
		.max_in(mic_max),
		.state_out(mic_state)
	);

	// ten agreeing samples always; debounce lengthens the pre-filter from one sample to four
	mhed_qualifier u_hook_db (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.sample_en_in(sample_q),
		.level_in(hook_lvl_q),
		.max_in(hook_max),
		.state_out(hook_raw)
	);
	assign hook_max = cfg_in.hookswitch_debounce_enable ?
		HOOK_DB_CNT_MAX : 4'h1;
	mhed_qualifier u_hook_q (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.sample_en_in(sample_q),
		.level_in(hook_raw),
		.max_in(HOOK_CNT_MAX),
		.state_out(hook_state)
	);

	// polarity 0 looks for presence/press, 1 for absence/release
	assign mic_hit = (mic_state != cfg_in.mic_present_event_polarity);
	assign hook_hit = (hook_state != cfg_in.hookswitch_event_polarity);

	// set wins over clear so a coincident event is kept
	always_comb begin
		mic_flag_d = mic_flag_q;
		hook_flag_d = hook_flag_q;
		if (clr_in.mic_present_flag_clear) begin
			mic_flag_d = 1'b0;
		end
		if (mic_hit) begin
			mic_flag_d = 1'b1;
		end
		if (clr_in.hookswitch_flag_clear) begin
			hook_flag_d = 1'b0;
		end
		if (hook_hit) begin
			hook_flag_d = 1'b1;
		end
		mic_pin_d = mic_state;
		hook_pin_d = hook_state;
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			mic_flag_q <= RST_FLAG;
			hook_flag_q <= RST_FLAG;
			mic_pin_q <= 1'b0;
			hook_pin_q <= 1'b0;
		end else begin
			mic_flag_q <= mic_flag_d;
			hook_flag_q <= hook_flag_d;
			mic_pin_q <= mic_pin_d;
			hook_pin_q <= hook_pin_d;
		end
	end

	assign mic_present_event_flag_out = mic_flag_q;
	assign hookswitch_event_flag_out = hook_flag_q;
	assign mic_present_state_out = mic_pin_q;
	assign hookswitch_state_out = hook_pin_q;

	// checker-only run of disagreeing samples seen by the hook decision,
	// kept apart from the qualifier so a miscount there is caught
	logic [3:0] hook_run_q, hook_run_d;

	always_comb begin
		hook_run_d = hook_run_q;
		if (sample_q) begin
			hook_run_d = (hook_raw != hook_state) ?
				hook_run_q + 4'h1 : RST_CNT;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			hook_run_q <= RST_CNT;
		end else begin
			hook_run_q <= hook_run_d;
		end
	end

	a_mic_flag_set: assert property (
		@(posedge clk_in) disable iff (reset_in)
		mic_hit |=> mic_flag_q)
		else $error("mic flag not raised on match");
	a_hook_flag_set: assert property (
		@(posedge clk_in) disable iff (reset_in)
		hook_hit |=> hook_flag_q)
		else $error("hook flag not raised on match");
	a_mic_sticky: assert property (
		@(posedge clk_in) disable iff (reset_in)
		mic_flag_q && !clr_in.mic_present_flag_clear |=> mic_flag_q)
		else $error("mic flag dropped without clear");
	a_hook_sticky: assert property (
		@(posedge clk_in) disable iff (reset_in)
		hook_flag_q && !clr_in.hookswitch_flag_clear |=> hook_flag_q)
		else $error("hook flag dropped without clear");
	a_mic_clear: assert property (
		@(posedge clk_in) disable iff (reset_in)
		clr_in.mic_present_flag_clear && !mic_hit |=> !mic_flag_q)
		else $error("mic flag kept after clear");
	a_hook_clear: assert property (
		@(posedge clk_in) disable iff (reset_in)
		clr_in.hookswitch_flag_clear && !hook_hit |=> !hook_flag_q)
		else $error("hook flag kept after clear");
	a_mic_no_false: assert property (
		@(posedge clk_in) disable iff (reset_in)
		!mic_flag_q ##1 mic_flag_q |-> $past(mic_hit))
		else $error("mic flag raised without match");
	a_hook_no_false: assert property (
		@(posedge clk_in) disable iff (reset_in)
		!hook_flag_q ##1 hook_flag_q |-> $past(hook_hit))
		else $error("hook flag raised without match");
	a_hook_state_hold: assert property (
		@(posedge clk_in) disable iff (reset_in)
		$changed(hook_state) |-> $past(sample_q))
		else $error("hook state moved off a sample");
	a_hook_ten: assert property (
		@(posedge clk_in) disable iff (reset_in)
		$changed(hook_state) |-> hook_run_q == HOOK_CNT_MAX)
		else $error("hook state moved without ten samples");
	a_pin_tracks: assert property (
		@(posedge clk_in) disable iff (reset_in)
		hook_pin_q == $past(hook_state) && mic_pin_q == $past(mic_state))
		else $error("status pin not following qualified state");
	a_mic_nodb: assert property (
		@(posedge clk_in) disable iff (reset_in)
		sample_q && !cfg_in.mic_present_debounce_enable
		&& mic_lvl_q != mic_state |=> mic_state == $past(mic_lvl_q))
		else $error("mic state lagged with debounce off");
	a_hook_nodb: assert property (
		@(posedge clk_in) disable iff (reset_in)
		sample_q && !cfg_in.hookswitch_debounce_enable
		&& hook_lvl_q != hook_raw |=> hook_raw == $past(hook_lvl_q))
		else $error("hook pre-filter lagged with debounce off");
	c_mic_flag: cover property (@(posedge clk_in) !mic_flag_q ##1 mic_flag_q);
	c_hook_flag: cover property (@(posedge clk_in) !hook_flag_q ##1 hook_flag_q);
	c_hook_rel: cover property (@(posedge clk_in)
		cfg_in.hookswitch_event_polarity && hook_hit);
	c_clear: cover property (@(posedge clk_in)
		hook_flag_q ##1 !hook_flag_q);
	c_mic_rel: cover property (@(posedge clk_in)
		cfg_in.mic_present_event_polarity && mic_hit);
endmodule

// [mhed_host_model.sv]
`timescale 1ns/100ps
// host side: sets polarity and debounce levels and pulses the flag clears
module mhed_host_model
	import mhed_pkg::*;
(
	// clock
	input wire logic clk_in,
	// controls
	output mhed_cfg_type cfg_out,
	output mhed_clr_type clr_out
);
	initial begin
		cfg_out = '0;
		clr_out = '0;
	end
	// polarity first: clearing before the flip would set the flag again
	task automatic flip_clear(input logic mic, input logic pol);
		@(posedge clk_in);
		if (mic) begin
			cfg_out.mic_present_event_polarity <= pol;
		end else begin
			cfg_out.hookswitch_event_polarity <= pol;
		end
		@(posedge clk_in);
		if (mic) begin
			clr_out.mic_present_flag_clear <= 1'b1;
		end else begin
			clr_out.hookswitch_flag_clear <= 1'b1;
		end
		@(posedge clk_in);
		clr_out <= '0;
	endtask
	task automatic set_db(input logic mic, input logic hook);
		@(posedge clk_in);
		cfg_out.mic_present_debounce_enable <= mic;
		cfg_out.hookswitch_debounce_enable <= hook;
	endtask
endmodule

// [testbench.sv]
`timescale 1ns/100ps
module testbench;
	import mhed_pkg::*;
	logic clk_in, reset_in, mic_cmp, hook_cmp;
	logic mic_flag, hook_flag, mic_pin, hook_pin;
	mhed_cfg_type cfg;
	mhed_clr_type clr;
	int n_errors = 0;
	int checks = 0;
	int n;
	mhed_event_detect dut_u (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.mic_present_cmp_in(mic_cmp),
		.hookswitch_cmp_in(hook_cmp),
		.cfg_in(cfg),
		.clr_in(clr),
		.mic_present_event_flag_out(mic_flag),
		.hookswitch_event_flag_out(hook_flag),
		.mic_present_state_out(mic_pin),
		.hookswitch_state_out(hook_pin)
	);
	mhed_host_model host_u (
		.clk_in(clk_in),
		.cfg_out(cfg),
		.clr_out(clr)
	);
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	task automatic check(input string what, input logic exp, input logic got);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %b, seen %b", what, exp, got);
		end
	endtask
	// polls one flag on falling edges, where outputs have settled
	task automatic poll(input logic mic, input int lim, output int cyc);
		cyc = 0;
		do begin
			@(negedge clk_in);
			cyc++;
		end while (((mic ? mic_flag : hook_flag) !== 1'b1) && cyc < lim);
	endtask
	task automatic print_verdict();
		if (n_errors == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		#200000;
		n_errors++;
		print_verdict();
	end
	initial begin
		mic_cmp = 1'b0;
		hook_cmp = 1'b0;
		reset_in = 1'b1;
		repeat (4) @(posedge clk_in);
		reset_in <= 1'b0;
		poll(1, 300, n);
		check("mic flag idle", 1'b0, mic_flag);
		check("hook flag idle", 1'b0, hook_flag);
		@(posedge clk_in) mic_cmp <= 1'b1;
		poll(1, 400, n);
		check("mic insert flag", 1'b1, mic_flag);
		check("mic pin", 1'b1, mic_pin);
		poll(0, 300, n);
		check("mic flag held", 1'b1, mic_flag);
		host_u.flip_clear(1'b1, 1'b1);
		poll(1, 3, n);
		check("mic flag clear", 1'b0, mic_flag);
		@(posedge clk_in) hook_cmp <= 1'b1;
		// earliest legal flag edge: sync 4, strobe 1, flag 1
		poll(0, HOOK_SAMPLES * SAMPLE_DIV + 6, n);
		check("hook press early", 1'b0, hook_flag);
		poll(0, 600, n);
		check("hook press flag", 1'b1, hook_flag);
		check("hook pin", 1'b1, hook_pin);
		host_u.flip_clear(1'b0, 1'b1);
		host_u.set_db(1'b1, 1'b1);
		@(negedge clk_in);
		check("hook flag clear", 1'b0, hook_flag);
		@(posedge clk_in) hook_cmp <= 1'b0;
		poll(0, (HOOK_SAMPLES + HOOK_DB_CNT_MAX - 1) * SAMPLE_DIV + 6, n);
		check("hook release early", 1'b0, hook_flag);
		poll(0, 800, n);
		check("hook release flag", 1'b1, hook_flag);
		check("hook pin low", 1'b0, hook_pin);
		host_u.flip_clear(1'b0, 1'b0);
		@(negedge clk_in);
		check("hook flag rearm", 1'b0, hook_flag);
		// a bounce of under four samples must be filtered out
		@(posedge clk_in) mic_cmp <= 1'b0;
		repeat (250) @(posedge clk_in);
		mic_cmp <= 1'b1;
		poll(1, 400, n);
		check("mic bounce", 1'b0, mic_flag);
		@(posedge clk_in) mic_cmp <= 1'b0;
		poll(1, 800, n);
		check("mic removal flag", 1'b1, mic_flag);
		check("mic pin low", 1'b0, mic_pin);
		host_u.flip_clear(1'b1, 1'b0);
		poll(1, 3, n);
		check("mic flag final", 1'b0, mic_flag);
		print_verdict();
	end
endmodule
